// ===== uqc_event_counter.sv
// What this block does
// (R01) rising edge on up input adds one to the counter
// (R02) rising edge on down input subtracts one from the counter
// (R03) rising edges on both inputs together leave the counter unchanged
// (R04) overflow goes high at the limit and holds until a valid reset
// (R05) underflow goes high when decrement reaches zero, holds until a valid reload or reset
// (R06) automatic reset: overflow for one cycle, then counter returns to zero
// (R07) manual reset clears counter after low-high-low with long enough high phase
// (R08) manual reset at the limit ignores up edges until a valid reset
// (R09) a valid reset pulse clears the counter even below the limit
// (R10) automatic reload: underflow for one cycle, then counter takes reload value
// (R11) manual reload loads after low-high-low with long enough high phase
// (R12) manual reload at zero ignores down edges until a valid reload
// (R13) a valid reload pulse loads the reload value at any count
// (R14) upper limit accepted from 1 to 65535, default 1000
// (R15) reload value accepted from 1 to 65535, default 1000
// (R16) software keeps the upper limit at or above the reload value
// (R17) reset high time minimum 100 or 350 ms, default 350, over 30 s invalid
// (R18) reload high time minimum 100 or 350 ms, default 350, over 30 s invalid
// (R19) reset beats reload and any counting edge
// (R20) pulse high times are counted in clocks and judged at the falling edge
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps

module uqc_pulse_qual #(
	parameter logic [31:0] MIN_LONG  = 32'h0000_0001,
	parameter logic [31:0] MIN_SHORT = 32'h0000_0001,
	parameter logic [31:0] MAX_HIGH  = 32'h0000_0002
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// pulse input and selection
	input  wire logic level,
	input  wire logic short_sel,
	// one-cycle accept
	output logic      valid
);
	uqc_pkg::uqc_qual_e          state;
	uqc_pkg::uqc_qual_e          next_state;
	logic [uqc_pkg::TMR_W-1:0]   high_cnt;
	logic [uqc_pkg::TMR_W-1:0]   next_high_cnt;
	logic                        next_valid;
	wire  [uqc_pkg::TMR_W-1:0]   min_cyc = short_sel ? MIN_SHORT : MIN_LONG;
	wire                         long_ok = high_cnt >= min_cyc;

	always_comb begin
		next_state    = state;
		next_high_cnt = high_cnt;
		next_valid    = 1'b0;
		case (state)
			uqc_pkg::UQC_Q_LOW: begin
				if (level) begin
					next_state    = uqc_pkg::UQC_Q_HIGH;
					next_high_cnt = uqc_pkg::TMR_ONE;
				end
			end
			uqc_pkg::UQC_Q_HIGH: begin
				if (!level) begin
					// judged only when the pulse ends (see R20)
					next_valid = long_ok; // see R17 see R18
					next_state = uqc_pkg::UQC_Q_LOW;
				end else if (high_cnt >= MAX_HIGH) begin
					// stuck high: the pulse can no longer qualify (see R17)
					next_state = uqc_pkg::UQC_Q_BLOCK;
				end else begin
					next_high_cnt = high_cnt + uqc_pkg::TMR_ONE; // see R20
				end
			end
			uqc_pkg::UQC_Q_BLOCK: begin
				// a low phase must be seen before a new pulse counts (see R07 see R11)
				if (!level)
					next_state = uqc_pkg::UQC_Q_LOW;
			end
			default: next_state = uqc_pkg::UQC_Q_BLOCK;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state    <= uqc_pkg::UQC_Q_BLOCK;
			high_cnt <= '0;
			valid    <= 1'b0;
		end else begin
			state    <= next_state;
			high_cnt <= next_high_cnt;
			valid    <= next_valid;
		end
	end
endmodule

module uqc_rise_det #(
	parameter logic IDLE = 1'b0
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// sampled line and its enable
	input  wire logic level,
	input  wire logic enable,
	// one-cycle rise
	output logic      rise
);
	logic level_d;

	// previous sample restarts at the idle level, so no false edge follows reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			level_d <= IDLE;
		else
			level_d <= level;
	end

	assign rise = level & ~level_d & enable;
endmodule

module uqc_event_counter #(
	parameter logic [31:0] MIN_LONG_CYC  = 32'(uqc_pkg::MIN_LONG_CYC),
	parameter logic [31:0] MIN_SHORT_CYC = 32'(uqc_pkg::MIN_SHORT_CYC),
	parameter logic [31:0] MAX_HIGH_CYC  = 32'(uqc_pkg::MAX_HIGH_CYC)
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// event inputs
	input  wire logic        up_count,
	input  wire logic        down_count,
	input  wire logic        counter_reset,
	input  wire logic        counter_reload,
	// flags and count value
	output logic             overflow,
	output logic             underflow,
	output logic [15:0]      count_value
);
	logic [uqc_pkg::CTRL_W-1:0]  ctrl;
	logic [uqc_pkg::CNT_W-1:0]   limit;
	logic [uqc_pkg::CNT_W-1:0]   reload_val;
	logic [uqc_pkg::CNT_W-1:0]   count;
	logic [uqc_pkg::CNT_W-1:0]   next_count;
	logic                        next_ovf;
	logic                        next_unf;
	logic                        ack;
	logic                        up_edge;
	logic                        dn_edge;
	logic                        rst_ok;
	logic                        rld_ok;

	// bus decode: one wait cycle, then the answer
	wire req      = avs_read | avs_write;
	wire wr_take  = avs_write & ack;
	wire sel_ctrl = avs_address == uqc_pkg::OFF_CTRL;
	wire sel_lim  = avs_address == uqc_pkg::OFF_LIMIT;
	wire sel_rld  = avs_address == uqc_pkg::OFF_RELOAD;
	wire sel_stat = avs_address == uqc_pkg::OFF_STATUS;
	wire full_lo  = &avs_byteenable[1:0];
	wire [uqc_pkg::CNT_W-1:0] wr_val = avs_writedata[uqc_pkg::CNT_W-1:0];
	// zero is outside the legal range, so such writes are dropped
	wire lim_we   = wr_take & sel_lim & full_lo & (wr_val != uqc_pkg::CNT_ZERO); // see R14
	wire rld_we   = wr_take & sel_rld & full_lo & (wr_val != uqc_pkg::CNT_ZERO); // see R15
	wire ctrl_we  = wr_take & sel_ctrl & avs_byteenable[0];

	assign avs_waitrequest = req & ~ack;

	wire [31:0] rd_mux =
		sel_ctrl ? {26'h0, ctrl} :
		sel_lim  ? {16'h0, limit} :
		sel_rld  ? {16'h0, reload_val} :
		sel_stat ? {14'h0, underflow, overflow, count} : 32'h0;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack          <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			ack          <= req & ~ack;
			avs_readdata <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl       <= uqc_pkg::CTRL_RESET;
			limit      <= uqc_pkg::LIMIT_DEF;
			reload_val <= uqc_pkg::RELOAD_DEF;
		end else begin
			if (ctrl_we)
				ctrl <= avs_writedata[uqc_pkg::CTRL_W-1:0];
			if (lim_we)
				limit <= wr_val;
			if (rld_we)
				reload_val <= wr_val;
		end
	end

	// pulse qualifiers for the reset and reload inputs
	uqc_pulse_qual #(
		.MIN_LONG  (MIN_LONG_CYC),
		.MIN_SHORT (MIN_SHORT_CYC),
		.MAX_HIGH  (MAX_HIGH_CYC)
	) u_rst_qual (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.level     (counter_reset),
		.short_sel (ctrl[uqc_pkg::CTRL_RST_SHORT]),
		.valid     (rst_ok)
	);

	uqc_pulse_qual #(
		.MIN_LONG  (MIN_LONG_CYC),
		.MIN_SHORT (MIN_SHORT_CYC),
		.MAX_HIGH  (MAX_HIGH_CYC)
	) u_rld_qual (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.level     (counter_reload),
		.short_sel (ctrl[uqc_pkg::CTRL_RLD_SHORT]),
		.valid     (rld_ok)
	);

	// count edge detection; a disabled direction never shows an edge
	uqc_rise_det #(
		.IDLE (1'b0)
	) u_up_det (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level   (up_count),
		.enable  (ctrl[uqc_pkg::CTRL_UP_EN]),
		.rise    (up_edge) // see R01
	);

	uqc_rise_det #(
		.IDLE (1'b0)
	) u_dn_det (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level   (down_count),
		.enable  (ctrl[uqc_pkg::CTRL_DOWN_EN]),
		.rise    (dn_edge) // see R02
	);

	wire auto_rst = ctrl[uqc_pkg::CTRL_AUTO_RST];
	wire auto_rld = ctrl[uqc_pkg::CTRL_AUTO_RLD];
	wire at_lim   = count == limit;
	wire at_zero  = count == uqc_pkg::CNT_ZERO;
	// a held flag freezes its direction until the qualified pulse
	wire up_go    = up_edge & ~dn_edge & ~overflow & ~at_lim;   // see R03 see R08
	wire dn_go    = dn_edge & ~up_edge & ~underflow & ~at_zero; // see R03 see R12
	wire inc_lim  = up_go & (count + uqc_pkg::CNT_ONE == limit);
	wire dec_zero = dn_go & (count == uqc_pkg::CNT_ONE);

	always_comb begin
		next_count = count;
		if (rst_ok)
			next_count = uqc_pkg::CNT_ZERO; // see R07 see R09 see R19
		else if (rld_ok)
			next_count = reload_val; // see R11 see R13
		else if (auto_rst & overflow)
			next_count = uqc_pkg::CNT_ZERO; // see R06
		else if (auto_rld & underflow)
			next_count = reload_val; // see R10
		else if (up_go)
			next_count = count + uqc_pkg::CNT_ONE; // see R01
		else if (dn_go)
			next_count = count - uqc_pkg::CNT_ONE; // see R02
	end

	always_comb begin
		if (rst_ok)
			next_ovf = 1'b0; // see R19
		else if (auto_rst)
			next_ovf = inc_lim & ~overflow; // see R06
		else
			next_ovf = overflow | inc_lim; // see R04
	end

	always_comb begin
		if (rst_ok | rld_ok)
			next_unf = 1'b0;
		else if (auto_rld)
			next_unf = dec_zero & ~underflow; // see R10
		else
			next_unf = underflow | dec_zero; // see R05
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count     <= uqc_pkg::CNT_ZERO;
			overflow  <= 1'b0;
			underflow <= 1'b0;
		end else begin
			count     <= next_count;
			overflow  <= next_ovf;
			underflow <= next_unf;
		end
	end

	assign count_value = count;
endmodule

// ===== uqc_event_counter_props.sv
`timescale 1ns/1ps
module uqc_event_counter_props (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// watched ports
	input wire logic        up_count,
	input wire logic        down_count,
	input wire logic        counter_reset,
	input wire logic        counter_reload,
	input wire logic        overflow,
	input wire logic        underflow,
	input wire logic [15:0] count_value
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// a landed pulse can look like one step, so steps right after a pulse are skipped
	AST_UP: assert property (count_value == $past(count_value) + 16'h0001 && !$past(underflow)
		&& !$past(counter_reset, 3) && !$past(counter_reload, 3) |-> $past(up_count) && !$past(up_count, 2))
		else $error("count rose without an up edge");
	AST_DOWN: assert property (count_value == $past(count_value) - 16'h0001 && !$past(overflow)
		&& !$past(counter_reset, 3) && !$past(counter_reload, 3) |-> $past(down_count) && !$past(down_count, 2))
		else $error("count fell without a down edge");
	AST_BOTH: assert property ($rose(up_count) && $rose(down_count) |=> $stable(count_value))
		else $error("count moved on two edges");
	AST_OVF_SET: assert property ($rose(overflow) |-> count_value == $past(count_value) + 16'h0001)
		else $error("overflow rose without a step up");
	AST_UNF_SET: assert property ($rose(underflow) |-> count_value == 16'h0000 && $past(count_value) == 16'h0001)
		else $error("underflow rose without a step to zero");
	AST_OVF_CLR: assert property ($fell(overflow) |-> count_value == 16'h0000)
		else $error("overflow fell without a clear");
	AST_UP_HELD: assert property (overflow && $rose(up_count) |=> $stable(count_value) || count_value == 16'h0000)
		else $error("up edge taken at limit");
	AST_DOWN_HELD: assert property (underflow && $rose(down_count) |=> $stable(count_value) || !underflow)
		else $error("down edge taken at zero");
	cover property ($rose(overflow));
	cover property ($rose(underflow));
	cover property ($rose(up_count) && $rose(down_count));
endmodule

bind uqc_event_counter uqc_event_counter_props u_props (.clk_sys(clk_sys), .rst(rst), .up_count(up_count),
	.down_count(down_count), .counter_reset(counter_reset), .counter_reload(counter_reload),
	.overflow(overflow), .underflow(underflow), .count_value(count_value));

// ===== uqc_event_counter_test.sv
`timescale 1ns/1ps
module uqc_event_counter_test;
	logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, overflow, underflow;
	logic        up_count, down_count, counter_reset, counter_reload;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rdv;
	logic [15:0] count_value;
	int          errors, total_checks, cnt, lim, rld, ctl, mo, mu;
	// mask, short select, high cycles, accepted
	int          pt[7][4] = '{'{1, 0, 19, 0}, '{2, 0, 20, 1}, '{1, 1, 7, 0}, '{1, 0, 61, 0},
		'{1, 0, 20, 1}, '{2, 1, 8, 1}, '{3, 0, 20, 1}};

	uqc_event_counter #(.MIN_LONG_CYC(32'h0000_0014), .MIN_SHORT_CYC(32'h0000_0008),
		.MAX_HIGH_CYC(32'h0000_003C)) dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.up_count(up_count), .down_count(down_count), .counter_reset(counter_reset),
		.counter_reload(counter_reload), .overflow(overflow), .underflow(underflow), .count_value(count_value));
	uqc_src_model src (.clk_sys(clk_sys), .up_count(up_count), .down_count(down_count),
		.counter_reset(counter_reset), .counter_reload(counter_reload));

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// a slave that never answers ends the run as a failure
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			end_of_test;
		end
	endtask
	task chk_all;
		chk("count", count_value, cnt);
		chk("overflow", overflow, mo);
		chk("underflow", underflow, mu);
	endtask
	task step(input logic u, input logic d);
		logic ue;
		logic de;
		// a disabled direction shows no edge at all
		ue = u && ctl[0];
		de = d && ctl[1];
		src.ev(u, d);
		if (ue && !de && mo == 0 && cnt != lim) begin
			cnt++;
			mo = (cnt == lim);
		end
		if (de && !ue && mu == 0 && cnt != 0) begin
			cnt--;
			mu = (cnt == 0);
		end
		#1;
		chk_all;
		if (mo == 1 && ctl[2]) begin
			cnt = 0;
			mo = 0;
		end
		if (mu == 1 && ctl[3]) begin
			cnt = rld;
			mu = 0;
		end
	endtask
	// the count moves one edge after the first low sample
	task pulse(input int m, input int n, input int v);
		src.pls(m[1:0], n);
		repeat (3) @(posedge clk_sys);
		#1;
		if (v == 1) begin
			cnt = m[0] ? 0 : rld;
			mo = m[0] ? 0 : mo;
			mu = 0;
		end
		chk_all;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		{rst, avs_read, avs_write, avs_address, avs_writedata} = {3'h4, 4'h0, 32'h0};
		avs_byteenable = 4'hF;
		{errors, total_checks, cnt, mo, mu, lim, rld, ctl} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3E8, 32'h3E8, 32'h3};
		void'($urandom(32'h94DE));
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		bus(1'b0, uqc_pkg::OFF_CTRL, 32'h0);
		chk("ctrl", rdv, 32'h03);
		bus(1'b1, uqc_pkg::OFF_LIMIT, 32'h0);
		// a limit write missing a low byte lane must be dropped
		avs_byteenable <= 4'h1;
		bus(1'b1, uqc_pkg::OFF_LIMIT, 32'h7);
		avs_byteenable <= 4'hF;
		bus(1'b0, uqc_pkg::OFF_LIMIT, 32'h0);
		chk("limit", rdv, 32'h3E8);
		bus(1'b0, uqc_pkg::OFF_RELOAD, 32'h0);
		chk("reload", rdv, 32'h3E8);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", rdv, 32'h0);
		bus(1'b1, uqc_pkg::OFF_LIMIT, 32'h5);
		bus(1'b1, uqc_pkg::OFF_RELOAD, 32'h3);
		{lim, rld} = {32'h5, 32'h3};
		$display("test registers done");
		repeat (60) step(1'($urandom_range(1)), 1'($urandom_range(1)));
		bus(1'b0, uqc_pkg::OFF_STATUS, 32'h0);
		chk("status", rdv, cnt + mo * 65536 + mu * 131072);
		$display("test counting done");
		// up disabled: up edges are dropped, down edges still count
		ctl = 2;
		bus(1'b1, uqc_pkg::OFF_CTRL, 32'h02);
		pulse(2, 20, 1);
		repeat (3) step(1'b1, 1'b0);
		step(1'b0, 1'b1);
		$display("test direction enable done");
		ctl = 3;
		bus(1'b1, uqc_pkg::OFF_CTRL, 32'h03);
		pulse(1, 20, 1);
		repeat (6) step(1'b1, 1'b0);
		repeat (6) step(1'b0, 1'b1);
		$display("test held flags done");
		foreach (pt[i]) begin
			bus(1'b1, uqc_pkg::OFF_CTRL, pt[i][1] ? 32'h33 : 32'h03);
			pulse(pt[i][0], pt[i][2], pt[i][3]);
		end
		$display("test pulses done");
		ctl = 15;
		bus(1'b1, uqc_pkg::OFF_CTRL, 32'h0F);
		pulse(1, 20, 1);
		repeat (6) step(1'b1, 1'b0);
		pulse(2, 20, 1);
		repeat (4) step(1'b0, 1'b1);
		$display("test auto modes done");
		end_of_test;
	end
endmodule

// ===== uqc_pkg.sv
package uqc_pkg;
	// register byte offsets
	localparam logic [3:0]  OFF_CTRL   = 4'h0;
	localparam logic [3:0]  OFF_LIMIT  = 4'h4;
	localparam logic [3:0]  OFF_RELOAD = 4'h8;
	localparam logic [3:0]  OFF_STATUS = 4'hC;

	// control fields
	localparam int CTRL_UP_EN      = 0;
	localparam int CTRL_DOWN_EN    = 1;
	localparam int CTRL_AUTO_RST   = 2;
	localparam int CTRL_AUTO_RLD   = 3;
	localparam int CTRL_RST_SHORT  = 4;
	localparam int CTRL_RLD_SHORT  = 5;
	localparam int CTRL_W          = 6;
	localparam logic [5:0] CTRL_RESET = 6'h03;

	// status fields above the count
	localparam int STAT_OVF = 16;
	localparam int STAT_UNF = 17;

	// counter range
	localparam int         CNT_W       = 16;
	localparam logic [15:0] LIMIT_DEF  = 16'h03E8;
	localparam logic [15:0] RELOAD_DEF = 16'h03E8;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CNT_ONE    = 16'h0001;

	// pulse timing
	localparam longint unsigned CLK_HZ     = 125000000;
	localparam longint unsigned MIN_LONG_MS  = 350;
	localparam longint unsigned MIN_SHORT_MS = 100;
	localparam longint unsigned MAX_HIGH_S   = 30;
	localparam longint unsigned MIN_LONG_CYC  = (MIN_LONG_MS * CLK_HZ + 999) / 1000;
	localparam longint unsigned MIN_SHORT_CYC = (MIN_SHORT_MS * CLK_HZ + 999) / 1000;
	localparam longint unsigned MAX_HIGH_CYC  = MAX_HIGH_S * CLK_HZ;

	localparam int          TMR_W   = 32;
	localparam logic [31:0] TMR_ONE = 32'h0000_0001;

	typedef enum logic [2:0] {
		UQC_Q_LOW   = 3'b001,
		UQC_Q_HIGH  = 3'b010,
		UQC_Q_BLOCK = 3'b100
	} uqc_qual_e;
endpackage

// ===== uqc_src_model.sv
`timescale 1ns/1ps
module uqc_src_model (
	// clock
	input  wire logic clk_sys,
	// event lines
	output logic      up_count,
	output logic      down_count,
	output logic      counter_reset,
	output logic      counter_reload
);
	initial {up_count, down_count, counter_reset, counter_reload} = 4'h0;
	// lines fall after each event so the next rise is a fresh edge
	task ev(input logic u, input logic d);
		@(posedge clk_sys);
		{up_count, down_count} <= {u, d};
		@(posedge clk_sys);
		{up_count, down_count} <= 2'h0;
	endtask
	// m bit 0 drives reset, bit 1 reload; n edges see the line high
	task pls(input logic [1:0] m, input int n);
		@(posedge clk_sys);
		{counter_reload, counter_reset} <= m;
		repeat (n) @(posedge clk_sys);
		{counter_reload, counter_reset} <= 2'h0;
	endtask
endmodule
